// *** logic/wwd_watchdog.sv ***
// Windowed watchdog timer counting on the slow on-chip oscillator
// Notes on behaviour
// - Count-enable option starts counting after reset
// - Key write before overflow clears counter
// - Later write in closed window resets
// - First write clears regardless of window
// - Overflow without key write resets
// - Single-bit access to kick register resets
// - Non-key byte written resets
// - Clear lands on next slow clock edge
// - Standby stops counter unless standby-run set
// - Leaving halt/stop clears counter when stopped
// - Overflow select picks period from table
// - Window select gives 50/75/100 percent open
// - Standby-run zero means always open
// - Interval irq at 75 percent of period
// - Interval irq leaves counter running
// - Spurious irq after late clear permitted
// - Watchdog reset sets reset-cause flag
// - Kick register reads 9a or 1a
// - Counter advances only on slow oscillator
module wwd_watchdog (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Slow on-chip oscillator pin
    input wire logic slowOscClk,
    // Option byte from the loader
    input wire wwd_pkg::wwd_opt_t optionByte,
    // CPU memory access
    input wire wwd_pkg::wwd_bus_t bus,
    output logic [7:0] kickRdata,
    // Standby modes
    input wire logic haltMode,
    input wire logic stopMode,
    input wire logic snoozeMode,
    // Reset cause flag clear
    input wire logic resetFlagClear,
    // Results
    output logic internalReset,
    output logic watchdogResetFlag,
    output logic intervalIrq
);
    wwd_pkg::wwd_state_t q;
    wwd_pkg::wwd_state_t d;
    logic tick;
    logic running;
    logic closedNow;
    logic fault;
    logic kickHit;
    logic [wwd_pkg::CNT_W-1:0] topVal;
    logic [wwd_pkg::CNT_W-1:0] irqPoint;
    logic wakeNow;

    // Power of two with the given exponent
    function automatic logic [wwd_pkg::CNT_W-1:0] pow2(input logic [4:0] e);
        pow2 = wwd_pkg::CNT_ONE << e;
    endfunction

    // Decode of period, window and interval point
    always_comb begin
        logic [4:0] e;
        logic [wwd_pkg::CNT_W-1:0] lim;
        e = wwd_pkg::OVF_EXP[q.opt.overflowSelect];
        lim = wwd_pkg::CNT_ZERO;
        topVal = pow2(e) - wwd_pkg::CNT_ONE;
        irqPoint = pow2(e) - pow2(e - wwd_pkg::SHIFT_QUARTER);
        // Code 00 is prohibited; it is treated as fully open
        if (q.opt.windowSelect == wwd_pkg::WIN_50) begin
            lim = pow2(e - wwd_pkg::SHIFT_HALF);
        end else if (q.opt.windowSelect == wwd_pkg::WIN_75) begin
            lim = pow2(e - wwd_pkg::SHIFT_QUARTER);
        end
        // Count restarts at zero on every clear, so the window follows it; a clear still
        // waiting for its slow edge counts as closed, as the count is about to restart
        closedNow = q.opt.standbyRunOption && q.opt.countEnableOption
            && (lim != wwd_pkg::CNT_ZERO)
            && (q.pendClear || (q.count < lim));
    end

    // Rising edge of the synchronised slow clock paces the counter
    assign tick = q.oscSync && !q.oscLast;
    assign running = q.optValid && q.opt.countEnableOption
        && !((haltMode || stopMode || snoozeMode) && !q.opt.standbyRunOption);
    assign kickHit = (bus.addr == wwd_pkg::KICK_ADDR);
    // Falling edge of halt or stop while standby stops the count
    assign wakeNow = q.standbyLast && !(haltMode || stopMode) && !q.opt.standbyRunOption;

    // Next state
    always_comb begin
        d = q;
        fault = 1'b0;
        d.rstPulse = 1'b0;
        d.irqPulse = 1'b0;
        d.oscMeta = slowOscClk;
        d.oscSync = q.oscMeta;
        d.oscLast = q.oscSync;
        d.standbyLast = haltMode || stopMode;
        // Options are caught once, after reset release
        if (!q.optValid) begin
            d.optValid = 1'b1;
            d.opt = optionByte;
        end
        // Read data never echoes the key
        d.rdata = wwd_pkg::READ_IDLE;
        if (bus.read && kickHit) begin
            d.rdata = q.opt.countEnableOption ? wwd_pkg::READ_COUNTING
                : wwd_pkg::READ_STOPPED;
        end
        // Counter: a pending clear waits for a slow edge, hence up to one slow cycle
        if (tick && q.pendClear) begin
            d.count = wwd_pkg::CNT_ZERO;
            d.pendClear = 1'b0;
        end else if (tick && running) begin
            if (q.count == topVal) begin
                fault = 1'b1;
            end else begin
                d.count = q.count + wwd_pkg::CNT_ONE;
                // A late clear gives no extra pulse here, which the spurious case allows
                if (q.opt.intervalIrqOption && (d.count == irqPoint)) begin
                    d.irqPulse = 1'b1;
                end
            end
        end
        // Wake from halt or stop restarts the count when standby stops it
        if (wakeNow) begin
            d.count = wwd_pkg::CNT_ZERO;
            d.irqPulse = 1'b0;
        end
        // Kick register writes
        if (bus.write && kickHit && q.optValid) begin
            if (bus.bitOp) begin
                fault = 1'b1;
            end else if (q.firstDone && closedNow) begin
                fault = 1'b1;
            end else if (bus.wdata != wwd_pkg::KICK_KEY) begin
                fault = 1'b1;
            end else begin
                d.pendClear = 1'b1;
                d.firstDone = 1'b1;
            end
        end
        // Internal reset restarts the watchdog as after power-up
        if (fault) begin
            d.rstPulse = 1'b1;
            d.count = wwd_pkg::CNT_ZERO;
            d.firstDone = 1'b0;
            d.pendClear = 1'b0;
            d.irqPulse = 1'b0;
        end
        // Set wins over software clear
        if (fault) begin
            d.rstFlag = 1'b1;
        end else if (resetFlagClear) begin
            d.rstFlag = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign kickRdata = q.rdata;
    assign internalReset = q.rstPulse;
    assign watchdogResetFlag = q.rstFlag;
    assign intervalIrq = q.irqPulse;

    // Checks
    sequence s_kickWrite;
        bus.write && kickHit && q.optValid;
    endsequence

    sequence s_goodFirst;
        s_kickWrite ##0 (!bus.bitOp && !q.firstDone && bus.wdata == wwd_pkg::KICK_KEY);
    endsequence

    property p_stopped;
        @(posedge clk) disable iff (!reset_n)
        (q.optValid && !q.opt.countEnableOption) |=> (q.count == wwd_pkg::CNT_ZERO);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while disabled");

    property p_keyPends;
        @(posedge clk) disable iff (!reset_n)
        (s_kickWrite ##0 (!bus.bitOp && !closedNow && bus.wdata == wwd_pkg::KICK_KEY))
            |=> (q.pendClear && !internalReset);
    endproperty
    a_keyPends: assert property (p_keyPends) else $error("key write not taken");

    property p_closedFault;
        @(posedge clk) disable iff (!reset_n)
        (s_kickWrite ##0 (q.firstDone && closedNow)) |=> internalReset;
    endproperty
    a_closedFault: assert property (p_closedFault) else $error("closed write missed");

    property p_firstFree;
        @(posedge clk) disable iff (!reset_n)
        s_goodFirst |=> (!internalReset && q.firstDone && q.pendClear);
    endproperty
    a_firstFree: assert property (p_firstFree) else $error("first write refused");

    property p_overflow;
        @(posedge clk) disable iff (!reset_n)
        (tick && running && !q.pendClear && q.count == topVal) |=> internalReset;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow without reset");

    property p_bitOp;
        @(posedge clk) disable iff (!reset_n)
        (s_kickWrite ##0 bus.bitOp) |=> (internalReset && watchdogResetFlag);
    endproperty
    a_bitOp: assert property (p_bitOp) else $error("bit access missed");

    property p_badKey;
        @(posedge clk) disable iff (!reset_n)
        (s_kickWrite ##0 (bus.wdata != wwd_pkg::KICK_KEY)) |=> internalReset;
    endproperty
    a_badKey: assert property (p_badKey) else $error("wrong key missed");

    property p_clearLands;
        @(posedge clk) disable iff (!reset_n)
        (tick && q.pendClear && !fault && !(bus.write && kickHit && q.optValid))
            |=> (q.count == wwd_pkg::CNT_ZERO && !q.pendClear);
    endproperty
    a_clearLands: assert property (p_clearLands) else $error("pending clear lost");

    property p_readValue;
        @(posedge clk) disable iff (!reset_n)
        (bus.read && kickHit && q.optValid) |=> (kickRdata ==
            ($past(q.opt.countEnableOption) ? wwd_pkg::READ_COUNTING : wwd_pkg::READ_STOPPED));
    endproperty
    a_readValue: assert property (p_readValue) else $error("kick read value wrong");

    property p_irqPoint;
        @(posedge clk) disable iff (!reset_n)
        intervalIrq |-> (q.count == irqPoint && q.opt.intervalIrqOption && !internalReset);
    endproperty
    a_irqPoint: assert property (p_irqPoint) else $error("irq misplaced");

    property p_standbyHold;
        @(posedge clk) disable iff (!reset_n)
        ((haltMode || stopMode || snoozeMode) && !q.opt.standbyRunOption && q.optValid
            && !q.pendClear && !fault && !wakeNow) |=> $stable(q.count);
    endproperty
    a_standbyHold: assert property (p_standbyHold) else $error("count moved");

    property p_standbyRun;
        @(posedge clk) disable iff (!reset_n)
        (tick && running && q.opt.standbyRunOption && (haltMode || stopMode || snoozeMode)
            && !q.pendClear && !fault) |=> (q.count == $past(q.count) + wwd_pkg::CNT_ONE);
    endproperty
    a_standbyRun: assert property (p_standbyRun) else $error("standby stalled");

    property p_wakeClear;
        @(posedge clk) disable iff (!reset_n)
        wakeNow |=> (q.count == wwd_pkg::CNT_ZERO);
    endproperty
    a_wakeClear: assert property (p_wakeClear) else $error("wake kept count");

    property p_tickOnly;
        @(posedge clk) disable iff (!reset_n)
        (!tick && !fault && !wakeNow) |=> $stable(q.count);
    endproperty
    a_tickOnly: assert property (p_tickOnly) else $error("count off tick");

    property p_irqFires;
        @(posedge clk) disable iff (!reset_n)
        (tick && running && !q.pendClear && q.opt.intervalIrqOption && !fault && !wakeNow
            && q.count == irqPoint - wwd_pkg::CNT_ONE) |=> intervalIrq;
    endproperty
    a_irqFires: assert property (p_irqFires) else $error("irq missing");

    property p_optHold;
        @(posedge clk) disable iff (!reset_n)
        q.optValid |=> $stable(q.opt);
    endproperty
    a_optHold: assert property (p_optHold) else $error("options moved");

    property p_rdataIdle;
        @(posedge clk) disable iff (!reset_n)
        !(bus.read && kickHit) |=> (kickRdata == wwd_pkg::READ_IDLE);
    endproperty
    a_rdataIdle: assert property (p_rdataIdle) else $error("read not idle");

    property p_flagWithReset;
        @(posedge clk) disable iff (!reset_n)
        internalReset |-> watchdogResetFlag;
    endproperty
    a_flagWithReset: assert property (p_flagWithReset) else $error("flag not set");

    property p_flagClear;
        @(posedge clk) disable iff (!reset_n)
        (resetFlagClear && !fault) |=> !watchdogResetFlag;
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("flag not cleared");

    property p_flagSticky;
        @(posedge clk) disable iff (!reset_n)
        (watchdogResetFlag && !resetFlagClear) |=> watchdogResetFlag;
    endproperty
    a_flagSticky: assert property (p_flagSticky) else $error("flag dropped");
endmodule // wwd_watchdog

// *** logic/wwd_pkg.sv ***
// Constants, option layout and state record of the windowed watchdog
package wwd_pkg;
    // Kick register address and values
    localparam logic [19:0] KICK_ADDR = 20'hfffab;
    localparam logic [7:0] KICK_KEY = 8'hac;
    localparam logic [7:0] READ_COUNTING = 8'h9a;
    localparam logic [7:0] READ_STOPPED = 8'h1a;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // Counter width and reset value
    localparam int CNT_W = 17;
    localparam logic [CNT_W-1:0] CNT_ZERO = 17'h00000;
    localparam logic [CNT_W-1:0] CNT_ONE = 17'h00001;
    // Window-select codes
    localparam logic [1:0] WIN_50 = 2'h1;
    localparam logic [1:0] WIN_75 = 2'h2;
    // Overflow exponents for codes 0 to 7
    localparam logic [4:0] OVF_EXP [8] = '{5'h06, 5'h07, 5'h08, 5'h09,
                                            5'h0b, 5'h0d, 5'h0e, 5'h10};
    // Shift steps: half of period is exp-1, quarter is exp-2
    localparam logic [4:0] SHIFT_HALF = 5'h01;
    localparam logic [4:0] SHIFT_QUARTER = 5'h02;

    // Option byte: bit 7 irq, 6..5 window, 4 count enable, 3..1 overflow, 0 standby run
    typedef struct packed {
        logic intervalIrqOption;
        logic [1:0] windowSelect;
        logic countEnableOption;
        logic [2:0] overflowSelect;
        logic standbyRunOption;
    } wwd_opt_t;

    // CPU access to the kick register
    typedef struct packed {
        logic [19:0] addr;
        logic write;
        logic read;
        logic bitOp;
        logic [7:0] wdata;
    } wwd_bus_t;

    // Whole state of the watchdog
    typedef struct packed {
        logic oscMeta;
        logic oscSync;
        logic oscLast;
        logic optValid;
        wwd_opt_t opt;
        logic [CNT_W-1:0] count;
        logic firstDone;
        logic pendClear;
        logic standbyLast;
        logic rstPulse;
        logic irqPulse;
        logic rstFlag;
        logic [7:0] rdata;
    } wwd_state_t;
endpackage

// *** testbench/wwd_watchdog_tb.sv ***
// Self-checking bench for the windowed watchdog
module wwd_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus and observed outputs
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic slowOscClk = 1'b0;
    wwd_pkg::wwd_opt_t optionByte = '0;
    wwd_pkg::wwd_bus_t bus = '0;
    logic haltMode = 1'b0;
    logic stopMode = 1'b0;
    logic snoozeMode = 1'b0;
    logic resetFlagClear = 1'b0;
    logic [7:0] kickRdata;
    logic internalReset;
    logic watchdogResetFlag;
    logic intervalIrq;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int slowDiv = 0;

    wwd_watchdog wwd_watchdog_i (
        .clk(clk), .reset_n(reset_n), .slowOscClk(slowOscClk), .optionByte(optionByte),
        .bus(bus), .kickRdata(kickRdata), .haltMode(haltMode), .stopMode(stopMode),
        .snoozeMode(snoozeMode), .resetFlagClear(resetFlagClear), .internalReset(internalReset),
        .watchdogResetFlag(watchdogResetFlag), .intervalIrq(intervalIrq));

    // System clock, 100 ns period
    always #50 clk = ~clk;
    // Slow oscillator at one eighth of the system rate, so periods stay short
    always @(negedge clk) begin
        slowDiv <= (slowDiv + 1) % 8;
        slowOscClk <= (slowDiv >= 4);
    end
    // Hang guard, well above the roughly nine thousand cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("Checks made: %0d, mismatches: %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Options are caught once after release, so every setup goes through reset
    task automatic restart(input logic [7:0] opt);
        @(negedge clk);
        reset_n = 1'b0;
        optionByte = wwd_pkg::wwd_opt_t'(opt);
        haltMode = 1'b0;
        stopMode = 1'b0;
        snoozeMode = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // One-cycle access to the kick register
    task automatic access(input logic wr, input logic bitop, input logic [7:0] data);
        bus.addr = wwd_pkg::KICK_ADDR;
        bus.write = wr;
        bus.read = !wr;
        bus.bitOp = bitop;
        bus.wdata = data;
        @(negedge clk);
        bus = '0;
    endtask

    // Counts reset and interrupt pulses over n cycles, the current cycle first
    task automatic run(input int n, output int rst, output int irq);
        rst = 0;
        irq = 0;
        repeat (n) begin
            rst += int'(internalReset === 1'b1);
            irq += int'(intervalIrq === 1'b1);
            @(negedge clk);
        end
    endtask

    // Read data stands for the one cycle after the access, then drops to idle
    task automatic t_read;
        int r, i;
        restart(8'h71);
        access(1'b0, 1'b0, 8'h00);
        chk("read enabled", wwd_pkg::READ_COUNTING, kickRdata);
        @(negedge clk);
        chk("read idle", wwd_pkg::READ_IDLE, kickRdata);
        restart(8'h61);
        access(1'b0, 1'b0, 8'h00);
        chk("read disabled", wwd_pkg::READ_STOPPED, kickRdata);
        run(700, r, i);
        chk("disabled overflow", 0, r);
    endtask

    task automatic t_faults;
        int r, i;
        restart(8'h71);
        access(1'b1, 1'b0, 8'h00);
        run(3, r, i);
        chk("wrong key reset", 1, r);
        chk("reset flag", 1, watchdogResetFlag);
        resetFlagClear = 1'b1;
        @(negedge clk);
        resetFlagClear = 1'b0;
        @(negedge clk);
        chk("flag cleared", 0, watchdogResetFlag);
        // Clear held through the faulting access: the set must win
        resetFlagClear = 1'b1;
        access(1'b1, 1'b1, wwd_pkg::KICK_KEY);
        resetFlagClear = 1'b0;
        run(3, r, i);
        chk("bit access reset", 1, r);
        chk("set beats clear", 1, watchdogResetFlag);
    endtask

    // Code 000 gives 64 slow ticks, 512 system cycles plus sync slack; code 001 twice that
    task automatic t_overflow;
        int r, i;
        restart(8'hf1);
        run(370, r, i);
        chk("early irq", 0, i);
        chk("early reset", 0, r);
        run(30, r, i);
        chk("irq at 75", 1, i);
        run(140, r, i);
        chk("overflow reset", 1, r);
        restart(8'h73);
        run(1000, r, i);
        chk("long period early", 0, r);
        run(60, r, i);
        chk("long period reset", 1, r);
    endtask

    task automatic t_kick;
        int r, i;
        restart(8'h71); // Interval irq off, so no masking step around kicks
        repeat (4) begin
            run(300, r, i);
            chk("kicked no reset", 0, r);
            access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        end
        run(300, r, i);
        chk("last kick holds", 0, r);
    endtask

    // 50 percent: closed below 32 ticks after a clear; 75 percent: below 16 ticks
    task automatic t_window;
        int r, i;
        restart(8'h31);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(20, r, i);
        chk("first write", 0, r);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(3, r, i);
        chk("closed write", 1, r);
        restart(8'h31);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(300, r, i);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(3, r, i);
        chk("open write", 0, r);
        restart(8'h51);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(60, r, i);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(3, r, i);
        chk("closed at 75", 1, r);
        restart(8'h51);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(200, r, i);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY); // After the prohibited span
        run(3, r, i);
        chk("open at 75", 0, r);
        restart(8'h30);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(20, r, i);
        access(1'b1, 1'b0, wwd_pkg::KICK_KEY);
        run(3, r, i);
        chk("always open", 0, r);
    endtask

    // Without the clear on exit, the ticks before and after halt would overflow
    task automatic t_halt;
        int r, i;
        restart(8'h70);
        run(300, r, i);
        haltMode = 1'b1;
        run(800, r, i);
        chk("halted", 0, r);
        haltMode = 1'b0;
        run(400, r, i);
        chk("halt exit clear", 0, r);
        stopMode = 1'b1;
        run(800, r, i);
        chk("stopped", 0, r);
        stopMode = 1'b0;
        run(400, r, i);
        chk("stop exit clear", 0, r);
        // Snooze stops the count too, but its exit keeps the count, so it runs out
        snoozeMode = 1'b1;
        run(800, r, i);
        chk("snoozed", 0, r);
        snoozeMode = 1'b0;
        run(400, r, i);
        chk("snooze exit keeps", 1, r);
        restart(8'h71);
        haltMode = 1'b1;
        run(600, r, i);
        chk("standby run overflow", 1, r);
    endtask

    initial begin
        t_read();
        t_faults();
        t_overflow();
        t_kick();
        t_window();
        t_halt();
        give_verdict();
    end
endmodule // wwd_watchdog_tb
